// ===== core/oec_operand_core.v
// operand formatting, addressing and read-modify-write sequencing
// Overview of operation
// RULE1: byte operations use only low 8 bits of acc_low_half.
// RULE2: word operations use the full 16-bit acc_low_half.
// RULE3: long operations join both halves, low half as low-order part.
// RULE4: acc_high_half holds the upper 16 bits of the accumulator.
// RULE5: short immediate is sign-extended from 8 to 16 bits.
// RULE6: short I/O form reaches only 000000h to 0000FFh, ignoring banks.
// RULE7: small vector selects 0 to 15, large vector 0 to 255.
// RULE8: ea codes 00 to 07 are registers, 08 to 1F memory.
// RULE9: physical address bits 0-15 are offset, 16-23 bank.
// RULE10: active stack pointer and bank follow user or system selection.
// RULE11: read-modify-write reads, processes and writes back one location.
// RULE12: software avoids read-modify-write on read/write-asymmetric addresses.
// RULE13: each flag is updated, set, cleared or kept per instruction.
`timescale 1ns/1ps
module oec_operand_core (
	input  wire        ref_clk,       // 50 MHz clock
	input  wire        sys_rst,       // async reset, active high
	input  wire [1:0]  opSize,        // byte/word/long
	input  wire [31:0] accIn,         // accumulator value
	input  wire [7:0]  shortImm,      // 8-bit immediate
	input  wire [7:0]  ioOffset,      // short I/O offset
	input  wire [3:0]  smallVector,   // 4-bit vector operand
	input  wire [7:0]  largeVector,   // 8-bit vector operand
	input  wire        vectorIsLarge, // selects the 8-bit vector
	input  wire [4:0]  eaCode,        // effective-address code
	input  wire [23:0] physAddr,      // physical direct address
	input  wire        stackSys,      // system stack selected
	input  wire [15:0] userSp,        // user stack pointer
	input  wire [15:0] sysSp,         // system stack pointer
	input  wire [7:0]  userBank,      // user stack bank
	input  wire [7:0]  sysBank,       // system stack bank
	input  wire        rmwStart,      // start read-modify-write
	input  wire [23:0] rmwAddr,       // its memory address
	input  wire [15:0] rmwAddend,     // value added to the operand
	input  wire [15:0] memRdata,      // memory read data
	input  wire        memAck,        // memory access done
	input  wire [4:0]  flagsIn,       // current N Z V C T
	input  wire [9:0]  flagCtl,       // per-flag action
	input  wire [4:0]  resultFlags,   // flags from result
	output reg  [31:0] accOperand_q,  // formatted accumulator operand
	output reg  [15:0] accHigh_q,     // upper accumulator half
	output reg  [15:0] immExt_q,      // sign-extended immediate
	output reg  [23:0] ioAddr_q,      // short I/O address
	output reg  [7:0]  vectorNum_q,   // selected vector number
	output reg         eaIsReg_q,     // ea is register direct
	output reg         eaIsMem_q,     // ea is memory
	output reg  [15:0] physOffset_q,  // in-bank offset
	output reg  [7:0]  physBank_q,    // bank number
	output reg  [15:0] activeSp_q,    // active stack pointer
	output reg  [7:0]  stackBank_q,   // current stack bank
	output reg         memRd_q,       // memory read request
	output reg         memWr_q,       // memory write request
	output reg  [23:0] memAddr_q,     // memory address
	output reg  [15:0] memWdata_q,    // memory write data
	output reg         rmwDone_q,     // one-cycle completion pulse
	output reg  [4:0]  flagsOut_q     // updated flags
);
`include "oec_defines.vh"
	// sequencer states, binary coded
	localparam [1:0] RMW_IDLE  = `OEC_RMW_IDLE;
	localparam [1:0] RMW_READ  = `OEC_RMW_READ;
	localparam [1:0] RMW_WRITE = `OEC_RMW_WRITE;
	// number of status flags handled by the flag unit
	localparam       NFLAG     = 5;

	// sequencer state and its next values
	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	reg  [15:0] data_q;
	reg  [15:0] data_d;
	reg         memRd_d;
	reg         memWr_d;
	reg  [23:0] memAddr_d;
	reg  [15:0] memWdata_d;
	reg         rmwDone_d;

	// next values of the decode outputs
	reg  [31:0] accOperand_d;
	reg  [15:0] accHigh_d;
	reg  [15:0] immExt_d;
	reg  [23:0] ioAddr_d;
	reg  [7:0]  vectorNum_d;
	reg         eaIsReg_d;
	reg         eaIsMem_d;
	reg  [15:0] physOffset_d;
	reg  [7:0]  physBank_d;
	reg  [15:0] activeSp_d;
	reg  [7:0]  stackBank_d;
	wire [4:0]  flagsOut_d;

	// widen an 8-bit value by copying its sign bit
	function [15:0] signExtend8;
		input [7:0] value;
		begin
			signExtend8 = {{8{value[`OEC_IMM_SIGN]}}, value};
		end
	endfunction

	// true when the ea code names a register rather than memory
	function isRegEa;
		input [4:0] code;
		begin
			isRegEa = (code <= `OEC_EA_REG_LAST);
		end
	endfunction

	// 16-bit add that wraps; the carry is dropped on purpose
	function [15:0] wrapAdd16;
		input [15:0] a;
		input [15:0] b;
		reg   [16:0] sum;
		begin
			sum       = {1'b0, a} + {1'b0, b};
			wrapAdd16 = sum[15:0];
		end
	endfunction

	// operand width from the size code; code 3 is undefined and acts as word
	always @* begin
		accOperand_d = {16'h0000, accIn[15:0]};
		case (opSize)
			`OEC_SZ_BYTE: accOperand_d = {24'h000000, accIn[7:0]};    // [RULE1]
			`OEC_SZ_WORD: accOperand_d = {16'h0000, accIn[15:0]};     // [RULE2]
			`OEC_SZ_LONG: accOperand_d = {accIn[31:16], accIn[15:0]}; // [RULE3]
			default:      accOperand_d = {16'h0000, accIn[15:0]};
		endcase
	end

	// field decode for immediates, addresses, vectors and stack selection
	always @* begin
		accHigh_d    = accIn[31:16];                                 // [RULE4]
		immExt_d     = signExtend8(shortImm);                        // [RULE5]
		// bank registers play no part, so the short form cannot leave the page
		ioAddr_d     = {16'h0000, ioOffset} & `OEC_IO_LAST;          // [RULE6]
		vectorNum_d  = vectorIsLarge ? largeVector : {4'h0, smallVector}; // [RULE7]
		eaIsReg_d    = isRegEa(eaCode);                              // [RULE8]
		eaIsMem_d    = ~isRegEa(eaCode);                             // [RULE8]
		physOffset_d = physAddr[15:0];                               // [RULE9]
		physBank_d   = physAddr[`OEC_BANK_LSB +: 8];                 // [RULE9]
		activeSp_d   = stackSys ? sysSp : userSp;                    // [RULE10]
		stackBank_d  = stackSys ? sysBank : userBank;                // [RULE10]
	end

	// per-flag action select
	oec_flag_unit #(.NFLAG(NFLAG)) i_oec_flag_unit (
		.flagsIn  (flagsIn),
		.resultIn (resultFlags),
		.flagCtl  (flagCtl),
		.flagsOut (flagsOut_d)
	);

	// decode results registered so every output leaves a flip-flop
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			accOperand_q <= 32'h00000000;
			accHigh_q    <= 16'h0000;
			immExt_q     <= 16'h0000;
			ioAddr_q     <= 24'h000000;
			vectorNum_q  <= 8'h00;
			eaIsReg_q    <= 1'b0;
			eaIsMem_q    <= 1'b0;
			physOffset_q <= 16'h0000;
			physBank_q   <= 8'h00;
			activeSp_q   <= 16'h0000;
			stackBank_q  <= 8'h00;
			flagsOut_q   <= 5'h00;
		end else begin
			accOperand_q <= accOperand_d;
			accHigh_q    <= accHigh_d;
			immExt_q     <= immExt_d;
			ioAddr_q     <= ioAddr_d;
			vectorNum_q  <= vectorNum_d;
			eaIsReg_q    <= eaIsReg_d;
			eaIsMem_q    <= eaIsMem_d;
			physOffset_q <= physOffset_d;
			physBank_q   <= physBank_d;
			activeSp_q   <= activeSp_d;
			stackBank_q  <= stackBank_d;
			flagsOut_q   <= flagsOut_d;   // [RULE13]
		end
	end

	// read-modify-write next state; address latched once so the write hits the same spot
	always @* begin
		state_d    = state_q;
		data_d     = data_q;
		memRd_d    = memRd_q;
		memWr_d    = memWr_q;
		memAddr_d  = memAddr_q;
		memWdata_d = memWdata_q;
		rmwDone_d  = 1'b0;
		case (state_q)
			RMW_IDLE: begin
				// only the idle state looks at start, so a start while busy is ignored
				if (rmwStart) begin
					memAddr_d = rmwAddr;   // [RULE11]
					data_d    = rmwAddend;
					memRd_d   = 1'b1;
					state_d   = RMW_READ;
				end
			end
			RMW_READ: begin
				if (memAck) begin
					memRd_d    = 1'b0;
					memWr_d    = 1'b1;
					memWdata_d = wrapAdd16(memRdata, data_q); // [RULE11]
					state_d    = RMW_WRITE;
				end
			end
			RMW_WRITE: begin
				if (memAck) begin
					memWr_d   = 1'b0;
					rmwDone_d = 1'b1;      // [RULE11]
					state_d   = RMW_IDLE;
				end
			end
			default: begin
				memRd_d = 1'b0;
				memWr_d = 1'b0;
				state_d = RMW_IDLE;
			end
		endcase
	end

	// sequencer registers
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q    <= RMW_IDLE;
			memRd_q    <= 1'b0;
			memWr_q    <= 1'b0;
			memAddr_q  <= 24'h000000;
			memWdata_q <= 16'h0000;
			data_q     <= 16'h0000;
			rmwDone_q  <= 1'b0;
		end else begin
			state_q    <= state_d;
			memRd_q    <= memRd_d;
			memWr_q    <= memWr_d;
			memAddr_q  <= memAddr_d;
			memWdata_q <= memWdata_d;
			data_q     <= data_d;
			rmwDone_q  <= rmwDone_d;
		end
	end
endmodule

// ===== core/oec_defines.vh
// constants for the operand encoding conventions block
`ifndef OEC_DEFINES_VH
`define OEC_DEFINES_VH
`define OEC_SZ_BYTE     2'h0
`define OEC_SZ_WORD     2'h1
`define OEC_SZ_LONG     2'h2
`define OEC_EA_REG_LAST 5'h07
`define OEC_IO_LAST     24'h0000ff
`define OEC_IMM_SIGN    3'h7
`define OEC_BANK_LSB    5'h10
`define OEC_FL_KEEP     2'h0
`define OEC_FL_UPD      2'h1
`define OEC_FL_SET      2'h2
`define OEC_FL_CLR      2'h3
`define OEC_RMW_IDLE    2'h0
`define OEC_RMW_READ    2'h1
`define OEC_RMW_WRITE   2'h2
`endif

// ===== core/oec_flag_unit.v
// per-flag update selector for five status flags
`timescale 1ns/1ps
module oec_flag_unit #(
	parameter NFLAG = 5
) (
	input  wire [NFLAG-1:0]   flagsIn,   // current flags
	input  wire [NFLAG-1:0]   resultIn,  // flags derived from result
	input  wire [2*NFLAG-1:0] flagCtl,   // two-bit action per flag
	output reg  [NFLAG-1:0]   flagsOut   // new flags
);
`include "oec_defines.vh"
	integer i;
	// exactly one action per flag
	always @* begin
		flagsOut = flagsIn;
		for (i = 0; i < NFLAG; i = i + 1) begin
			case (flagCtl[2*i +: 2])
				`OEC_FL_UPD: flagsOut[i] = resultIn[i]; // [RULE13]
				`OEC_FL_SET: flagsOut[i] = 1'b1;         // [RULE13]
				`OEC_FL_CLR: flagsOut[i] = 1'b0;         // [RULE13]
				default: flagsOut[i] = flagsIn[i];       // [RULE13]
			endcase
		end
	end
endmodule

// ===== dv/oec_core_monitor.sv
// port checker for the operand core
`timescale 1ns/1ps
module oec_core_monitor (
	input wire logic        ref_clk,      // block clock
	input wire logic        sys_rst,      // async reset, active high
	input wire logic        memAck,       // memory access done
	input wire logic        memRd_q,      // read request
	input wire logic        memWr_q,      // write request
	input wire logic        rmwDone_q,    // completion pulse
	input wire logic [1:0]  opSize,       // operand size code
	input wire logic [31:0] accIn,        // accumulator in
	input wire logic [31:0] accOperand_q, // formatted operand
	input wire logic [15:0] accHigh_q,    // upper half out
	input wire logic [15:0] immExt_q,     // extended immediate
	input wire logic [15:0] memRdata,     // read data
	input wire logic [15:0] rmwAddend,    // value added
	input wire logic [15:0] memWdata_q,   // write data
	input wire logic [7:0]  shortImm,     // short immediate
	input wire logic [7:0]  ioOffset,     // short i/o offset
	input wire logic [23:0] ioAddr_q,     // short i/o address
	input wire logic [23:0] memAddr_q,    // memory address
	input wire logic [23:0] physAddr,     // physical address in
	input wire logic [15:0] physOffset_q, // in-bank offset
	input wire logic [7:0]  physBank_q,   // bank number
	input wire logic [4:0]  eaCode,       // ea code
	input wire logic        eaIsReg_q,    // register class
	input wire logic        eaIsMem_q     // memory class
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	byte_op_a: assert property (opSize == 2'h0 |=> accOperand_q == {24'h0, $past(accIn[7:0])})
		else $error("byte operand wrong");
	word_op_a: assert property (opSize == 2'h1 |=> accOperand_q[15:0] == $past(accIn[15:0]))
		else $error("word operand wrong");
	long_op_a: assert property (opSize == 2'h2 |=> accOperand_q == $past(accIn))
		else $error("long operand wrong");
	acc_high_a: assert property (1 |=> accHigh_q == $past(accIn[31:16]))
		else $error("high half wrong");
	imm_ext_a: assert property (1 |=> immExt_q == {{8{$past(shortImm[7])}}, $past(shortImm)})
		else $error("immediate not extended");
	io_page_a: assert property (1 |=> ioAddr_q == {16'h0, $past(ioOffset)})
		else $error("io address off page");
	ea_split_a: assert property (1 |=> eaIsReg_q == ($past(eaCode) <= 5'h07) && eaIsMem_q != eaIsReg_q)
		else $error("ea class wrong");
	phys_split_a: assert property (1 |=> {physBank_q, physOffset_q} == $past(physAddr))
		else $error("physical split wrong");
	rmw_write_a: assert property (memRd_q && memAck |=> memWr_q && !memRd_q
		&& memWdata_q == $past(memRdata) + $past(rmwAddend) && $stable(memAddr_q))
		else $error("write back wrong");
	rmw_done_a: assert property (memWr_q && memAck |=> rmwDone_q && !memWr_q ##1 !rmwDone_q)
		else $error("done pulse wrong");
	cover property (memWr_q && memAck);
	cover property (opSize == 2'h2);
	cover property (eaCode == 5'h1f);
endmodule
bind oec_operand_core oec_core_monitor i_oec_core_monitor (.*);

// ===== dv/oec_operand_core_bench.sv
// self-checking bench for the operand core
`timescale 1ns/1ps
module oec_operand_core_bench;
	logic ref_clk = 0, sys_rst = 1, rmwStart = 0, memAck = 0;
	logic [1:0] opSize = 0;
	logic [31:0] accIn = 0, accOperand_q, exp;
	logic [15:0] rmwAddend = 0, memRdata = 0, accHigh_q, immExt_q;
	logic [15:0] physOffset_q, activeSp_q, memWdata_q;
	logic [23:0] rmwAddr = 0, ioAddr_q, memAddr_q;
	logic [4:0] flagsIn = 0, resultFlags = 0, flagsOut_q;
	logic [7:0] vectorNum_q, physBank_q, stackBank_q;
	logic eaIsReg_q, eaIsMem_q, memRd_q, memWr_q, rmwDone_q;
	int failures = 0, nCompared = 0;
	// all decode inputs come from accIn so each row exercises every field
	wire [7:0] shortImm = accIn[7:0], ioOffset = accIn[15:8], largeVector = accIn[7:0];
	wire [7:0] userBank = accIn[23:16], sysBank = accIn[31:24];
	wire [3:0] smallVector = accIn[3:0];
	wire [4:0] eaCode = accIn[4:0];
	wire [23:0] physAddr = accIn[23:0];
	wire [15:0] userSp = accIn[15:0], sysSp = ~accIn[15:0];
	wire vectorIsLarge = accIn[31], stackSys = accIn[30];
	// 1e4 gives flags 4..0 update, clear, set, update, keep; 31b clear, keep, update, set, clear
	logic [9:0] flagCtl = 10'h1e4;
	logic [65:0] rows [4] = '{{2'h0, 32'h89abcd80, 32'h00000080}, {2'h1, 32'h1234f07f, 32'h0000f07f},
		{2'h2, 32'hfedc0a07, 32'hfedc0a07}, {2'h3, 32'h4f001508, 32'h00001508}};
	oec_operand_core i_oec_operand_core (.*);
	always #10 ref_clk = ~ref_clk;
	task automatic chk(input string nm, input logic [31:0] seen, expv);
		nCompared++;
		if (seen !== expv) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, expv, seen);
		end
	endtask
	// start is held through the read phase to show it is ignored while busy
	// targets are plain memory with the same meaning on read and write
	task automatic read_modify_write(input logic [15:0] rd, ad, input int lat);
		rmwAddr = {8'h5a, rd};
		rmwAddend = ad;
		rmwStart = 1;
		for (int k = 0; k < 20 && memRd_q !== 1'b1; k++) @(negedge ref_clk);
		repeat (lat) @(negedge ref_clk);
		chk("read", {memRd_q, memAddr_q}, {1'b1, 8'h5a, rd});
		memRdata = rd;
		memAck = 1;
		@(negedge ref_clk);
		memAck = 0;
		memRdata = ~rd;
		repeat (lat) @(negedge ref_clk);
		chk("write", {memWr_q, memRd_q, memWdata_q}, {2'h2, 16'(rd + ad)});
		chk("waddr", memAddr_q, {8'h5a, rd});
		rmwStart = 0;
		memAck = 1;
		@(negedge ref_clk);
		memAck = 0;
		chk("done", {rmwDone_q, memWr_q}, 2'h2);
		@(negedge ref_clk);
		chk("idle", {rmwDone_q, memRd_q}, 2'h0);
	endtask
	task finish_test;
		if (failures == 0 && nCompared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge ref_clk);
		chk("reset", {accOperand_q[28:0], memRd_q, memWr_q, rmwDone_q}, 0);
		sys_rst = 0;
		for (int i = 0; i < 4; i++) begin
			{opSize, accIn, exp} = rows[i];
			flagsIn = 5'h0a ^ {5{i[0]}};
			resultFlags = 5'h14 ^ {5{i[0]}};
			flagCtl = i[1] ? 10'h31b : 10'h1e4;
			@(negedge ref_clk);
			chk("operand", accOperand_q, exp);
			chk("high", accHigh_q, accIn[31:16]);
			chk("imm", immExt_q, {{8{accIn[7]}}, accIn[7:0]});
			chk("io", ioAddr_q, {16'h0, accIn[15:8]});
			chk("vector", vectorNum_q, accIn[31] ? accIn[7:0] : {4'h0, accIn[3:0]});
			chk("ea", {eaIsReg_q, eaIsMem_q}, accIn[4:0] < 5'h08 ? 2'h2 : 2'h1);
			chk("phys", {physBank_q, physOffset_q}, accIn[23:0]);
			chk("stack", {stackBank_q, activeSp_q}, stackSys ? {sysBank, sysSp} : accIn[23:0]);
			chk("flags", flagsOut_q, i[1] ? (i[0] ? 5'h02 : 5'h0e) : (i[0] ? 5'h07 : 5'h14));
		end
		read_modify_write(16'hfff0, 16'h0020, 0);
		read_modify_write(16'h1234, 16'h0101, 3);
		// reset in mid-read must abandon the access, then a fresh one must run
		rmwAddr = 24'h5a0042;
		rmwStart = 1;
		@(negedge ref_clk);
		chk("busy", memRd_q, 1);
		rmwStart = 0;
		sys_rst = 1;
		@(negedge ref_clk);
		chk("abort", {memRd_q, memWr_q, rmwDone_q, memAddr_q}, 0);
		sys_rst = 0;
		read_modify_write(16'h0042, 16'hffff, 1);
		finish_test;
	end
	// watchdog far beyond the few dozen cycles the run needs
	initial begin
		#100000;
		failures++;
		finish_test;
	end
endmodule
